// File: rtl/dbfsa_top.sv
// Control arbitration, latched fault status and alerts for two management buses

// Functional notes
// - Normal and bad commands are acted upon only from the bus in control; other bus must take over.
// - Normal or bad command on idle bus is rejected, its alert asserted, transfer status records it.
// - Clear-faults from controlling bus never drops the idle bus's alert.
// - Clear-faults on any bus drops its own alert and its pending status.
// - Unit fault asserts both alerts and is reported in status word.
// - Control handover asserts both alerts and is recorded in transfer status.
// - Alert stays asserted while that bus's transfer status holds uncleared information.
// - Bad command on controlling bus sets command error bits and that bus's alert.
// - Fault status bits stay latched until a clear-faults command from the controlling bus.
// - Unit alarms never change the transfer status record.
// - Isolation test pass or fail stays latched until clear-faults from the controlling bus.
// - Output shutdown indication stays latched.
// - Voltage, current, input, unknown, comm and internal faults all stay latched.
// - Overcurrent and overtemperature response settings change only by explicit write.
// - Persisting fault re-latches right after clear; live state is never latched.
// - No restart-successful bit; latched faults carry that information.
module dbfsa_top
  import dbfsa_pkg::*;
#(
  parameter int RESP_W = 8
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [dbfsa_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [dbfsa_pkg::NBUS-1:0]    cmd_valid,
  input  wire logic [2*dbfsa_pkg::NBUS-1:0]  cmd_kind,
  input  wire logic [dbfsa_pkg::FLT_W-1:0]   fault_pin,
  output logic      [dbfsa_pkg::NBUS-1:0]    alert_n,
  output logic      [dbfsa_pkg::NBUS-1:0]    cmd_accept,
  output logic                               ctrl_bus,
  output logic      [RESP_W-1:0]             oc_resp,
  output logic      [RESP_W-1:0]             ot_resp,
  output logic                               irq
);
  import dbfsa_pkg::*;

  initial begin
    if (RESP_W < 1 || 2 * RESP_W > 32) $error("RESP_W out of range");
    if (NBUS != 2) $error("Arbitration serves exactly two buses");
    if (SW_FLT_LSB + FLT_W != SW_W) $error("Status word layout mismatch");
  end

  // Fault pins come from the power stage, outside this clock domain
  logic [FLT_W-1:0]         flt_meta_ff;
  logic [FLT_W-1:0]         flt_live_ff;
  logic [FLT_W-1:0]         flt_prev_ff;
  logic [FLT_W-1:0]         flt_lat_ff;
  logic                     cml_lat_ff;
  logic                     ctrl_bus_ff;
  logic [NBUS-1:0][3:1]     xf_ff;
  logic [NBUS-1:0]          pend_ff;
  logic [NBUS-1:0]          alert_n_ff;
  logic [NBUS-1:0]          cmd_accept_ff;
  logic [2*RESP_W-1:0]      resp_cfg_ff;
  logic [IRQ_W-1:0]         irq_stat_ff;
  logic [IRQ_W-1:0]         irq_mask_ff;
  logic                     irq_ff;
  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;

  wire  [FLT_W-1:0]         flt_live = flt_live_ff;
  wire  [FLT_W-1:0]         flt_rise = flt_live_ff & ~flt_prev_ff;
  wire                      any_rise = |flt_rise;

  // Per-bus command decode
  logic [NBUS-1:0]          is_ctrl;
  logic [NBUS-1:0]          cmd_clr;
  logic [NBUS-1:0]          cmd_take;
  logic [NBUS-1:0]          cmd_rej;
  logic [NBUS-1:0]          cmd_bad;
  logic [NBUS-1:0]          cmd_ok;
  logic [NBUS-1:0][3:1]     nxt_xf;
  logic [NBUS-1:0]          nxt_pend;

  wire                      handover = |cmd_take;
  wire                      nxt_ctrl_bus = handover ? ~ctrl_bus_ff : ctrl_bus_ff;
  wire                      ctrl_clr = cmd_clr[ctrl_bus_ff];

  for (genvar b = 0; b < NBUS; b++) begin : g_bus
    wire dbfsa_cmd_t kind = dbfsa_cmd_t'(cmd_kind[2*b +: 2]);
    assign is_ctrl[b]  = (ctrl_bus_ff == 1'(b));
    assign cmd_clr[b]  = cmd_valid[b] && kind == CMD_CLEAR;
    // A takeover from the bus already in control changes nothing
    assign cmd_take[b] = cmd_valid[b] && kind == CMD_TAKEOVER && !is_ctrl[b];
    assign cmd_rej[b]  = cmd_valid[b] && !is_ctrl[b]
                         && (kind == CMD_NORMAL || kind == CMD_BAD);
    assign cmd_bad[b]  = cmd_valid[b] && is_ctrl[b] && kind == CMD_BAD;
    assign cmd_ok[b]   = cmd_valid[b] && is_ctrl[b] && kind == CMD_NORMAL;
    // Own clear only; new events in the same cycle win over the clear
    assign nxt_xf[b][XF_REJ]   = (xf_ff[b][XF_REJ] && !cmd_clr[b]) || cmd_rej[b];
    assign nxt_xf[b][XF_EVENT] = (xf_ff[b][XF_EVENT] && !cmd_clr[b])
                                 || cmd_rej[b] || handover;
    assign nxt_xf[b][XF_TOOK]  = (xf_ff[b][XF_TOOK] && !cmd_clr[b]) || cmd_take[b];
    // Pending alert: only this bus's own clear removes it
    assign nxt_pend[b] = (pend_ff[b] && !cmd_clr[b]) || any_rise || cmd_bad[b];
  end

  // Clear reloads with live faults so a persisting fault re-latches at once
  wire  [FLT_W-1:0] nxt_flt_lat = (ctrl_clr ? '0 : flt_lat_ff) | flt_live;
  wire              nxt_cml_lat = (cml_lat_ff && !ctrl_clr) || (|cmd_bad);

  // Restart success is implied by latched faults clearing, no own bit
  wire  [SW_W-1:0]  status_word = {flt_lat_ff, {(SW_FLT_LSB - SW_CML_BIT - 1){1'b0}},
                                   cml_lat_ff, {SW_CML_BIT{1'b0}}};
  wire  [CML_W-1:0] cml_byte    = {cml_lat_ff, {CML_BAD_BIT{1'b0}}};
  wire  [7:0]       xfer_byte   = {xf_ff[1], ctrl_bus_ff, xf_ff[0], ~ctrl_bus_ff};

  // Interrupt events
  logic [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_FAULT]    = any_rise;
  assign irq_ev[IRQ_HANDOVER] = handover;
  assign irq_ev[IRQ_REJECT]   = |cmd_rej;
  assign irq_ev[IRQ_BADCMD]   = |cmd_bad;

  // APB decode; one wait state so read data comes from a flop
  wire hit_sw   = paddr == REG_STATUS_WORD;
  wire hit_cml  = paddr == REG_STATUS_CML;
  wire hit_xf   = paddr == REG_XFER_STATUS;
  wire hit_live = paddr == REG_LIVE_STATE;
  wire hit_resp = paddr == REG_RESP_CFG;
  wire hit_irqs = paddr == REG_IRQ_STATUS;
  wire hit_mask = paddr == REG_IRQ_MASK;
  wire hit_any  = hit_sw | hit_cml | hit_xf | hit_live | hit_resp | hit_irqs | hit_mask;
  wire acc_ph   = psel && penable && !pready_ff;
  wire done     = psel && penable && pready_ff;
  wire wr_en    = done && pwrite && hit_any;

  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_sw) begin
      rd_data = 32'(status_word);
    end else if (hit_cml) begin
      rd_data = 32'(cml_byte);
    end else if (hit_xf) begin
      rd_data = 32'(xfer_byte);
    end else if (hit_live) begin
      // Operational state is reported live, never latched
      rd_data = 32'({ctrl_bus_ff, flt_live});
    end else if (hit_resp) begin
      rd_data = 32'(resp_cfg_ff);
    end else if (hit_irqs) begin
      rd_data = 32'(irq_stat_ff);
    end else if (hit_mask) begin
      rd_data = 32'(irq_mask_ff);
    end
  end

  wire [IRQ_W-1:0] irq_w1c = (wr_en && hit_irqs) ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_w1c) | irq_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_meta_ff <= '0;
      flt_live_ff <= '0;
      flt_prev_ff <= '0;
    end else begin
      flt_meta_ff <= fault_pin;
      flt_live_ff <= flt_meta_ff;
      flt_prev_ff <= flt_live_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_lat_ff    <= '0;
      cml_lat_ff    <= 1'b0;
      ctrl_bus_ff   <= CTRL_BUS_RST;
      xf_ff         <= '0;
      pend_ff       <= '0;
      alert_n_ff    <= '1;
      cmd_accept_ff <= '0;
    end else begin
      flt_lat_ff    <= nxt_flt_lat;
      cml_lat_ff    <= nxt_cml_lat;
      ctrl_bus_ff   <= nxt_ctrl_bus;
      xf_ff         <= nxt_xf;
      pend_ff       <= nxt_pend;
      for (int b = 0; b < NBUS; b++) begin
        alert_n_ff[b] <= !(nxt_pend[b] || (|nxt_xf[b]));
      end
      cmd_accept_ff <= cmd_ok;
    end
  end

  // Response settings: only an explicit register write alters them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_cfg_ff <= '0;
    end else if (wr_en && hit_resp) begin
      resp_cfg_ff <= pwdata[2*RESP_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_en && hit_mask) begin
        irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
      irq_ff      <= |(nxt_irq_stat & (wr_en && hit_mask ? pwdata[IRQ_W-1:0] : irq_mask_ff));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc_ph;
      if (acc_ph) begin
        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_ff <= !hit_any;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign alert_n    = alert_n_ff;
  assign cmd_accept = cmd_accept_ff;
  assign ctrl_bus   = ctrl_bus_ff;
  assign oc_resp    = resp_cfg_ff[RESP_W-1:0];
  assign ot_resp    = resp_cfg_ff[2*RESP_W-1:RESP_W];
  assign irq        = irq_ff;

  // Checks tying outputs to their causes
  for (genvar b = 0; b < NBUS; b++) begin : g_chk
    reject_not_acted_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      cmd_rej[b] |=> !cmd_accept_ff[b])
      else $error("rejected command was acted upon");
    reject_alert_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      cmd_rej[b] |=> !alert_n_ff[b] && xf_ff[b][XF_REJ] && xf_ff[b][XF_EVENT])
      else $error("rejection not recorded or alert missing");
    idle_keeps_alert_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctrl_clr && !is_ctrl[b] && !cmd_clr[b] && (pend_ff[b] || |xf_ff[b]))
      |=> !alert_n_ff[b])
      else $error("controlling clear dropped idle bus alert");
    own_clear_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_clr[b] && !any_rise && !handover && !cmd_rej[b] && !cmd_bad[b])
      |=> alert_n_ff[b] && !pend_ff[b] && xf_ff[b] == 3'h0)
      else $error("own clear did not drop alert");
    bad_cmd_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      cmd_bad[b] |=> cml_lat_ff && status_word[SW_CML_BIT] && !alert_n_ff[b])
      else $error("bad command not reported");
    alert_hold_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (|xf_ff[b]) |-> !alert_n_ff[b])
      else $error("alert dropped with transfer status pending");
    accept_pulse_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      cmd_ok[b] |=> cmd_accept_ff[b])
      else $error("accepted command not flagged");
    pend_hold_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (pend_ff[b] && !cmd_clr[b]) |=> pend_ff[b])
      else $error("pending alert lost without own clear");
    pend_quiet_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (!pend_ff[b] && !any_rise && !cmd_bad[b]) |=> !pend_ff[b])
      else $error("pending alert set without cause");
    xfer_hold_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      !cmd_clr[b] |=> (xf_ff[b] & $past(xf_ff[b])) == $past(xf_ff[b]))
      else $error("transfer status lost without own clear");
    pend_fault_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      any_rise |=> pend_ff[b])
      else $error("fault did not set pending alert");
    reject_no_cml_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_rej[b] && !cml_lat_ff && !(|cmd_bad)) |=> !cml_lat_ff)
      else $error("rejected command flagged as command error");
    alert_release_a : assert property (
      @(posedge pclk) disable iff (!presetn)
      (!pend_ff[b] && xf_ff[b] == 3'h0) |-> alert_n_ff[b])
      else $error("alert held with nothing pending");
  end

  fault_both_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    any_rise |=> alert_n_ff == 2'b00 ##0 (flt_lat_ff & $past(flt_rise)) == $past(flt_rise))
    else $error("fault did not raise both alerts");
  handover_both_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    handover |=> ctrl_bus_ff != $past(ctrl_bus_ff) && alert_n_ff == 2'b00
                 && xf_ff[ctrl_bus_ff][XF_TOOK])
    else $error("handover not recorded");
  latch_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_clr |=> (flt_lat_ff & $past(flt_lat_ff)) == $past(flt_lat_ff))
    else $error("latched fault lost without clear");
  relatch_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_clr |=> flt_lat_ff == $past(flt_live))
    else $error("persisting fault not re-latched");
  alarm_no_xfer_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (any_rise && cmd_valid == 2'b00) |=> $stable(xf_ff))
    else $error("alarm touched transfer status");
  resp_stable_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && hit_resp) |=> $stable(resp_cfg_ff))
    else $error("response settings changed without write");

  // Control only moves on a takeover from the idle bus
  ctrl_steady_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !handover |=> $stable(ctrl_bus_ff))
    else $error("control moved without takeover");
  handover_event_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    handover |=> xf_ff[0][XF_EVENT] && xf_ff[1][XF_EVENT])
    else $error("handover event missing on a bus");

  // Latched status survives everything but a controlling clear
  cml_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (cml_lat_ff && !ctrl_clr) |=> cml_lat_ff)
    else $error("command error lost without clear");
  cml_clear_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_clr && !(|cmd_bad)) |=> !cml_lat_ff)
    else $error("command error survived clear");
  shutdown_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (flt_lat_ff[FLT_SHUTDOWN] && !ctrl_clr) |=> flt_lat_ff[FLT_SHUTDOWN])
    else $error("shutdown indication lost without clear");
  iso_pass_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (flt_lat_ff[FLT_ISO_PASS] && !ctrl_clr) |=> flt_lat_ff[FLT_ISO_PASS])
    else $error("isolation pass lost without clear");
  iso_fail_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (flt_lat_ff[FLT_ISO_FAIL] && !ctrl_clr) |=> flt_lat_ff[FLT_ISO_FAIL])
    else $error("isolation fail lost without clear");
  fault_status_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    any_rise |=> |status_word[SW_W-1:SW_FLT_LSB])
    else $error("fault not shown in status word");
  resp_write_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit_resp) |=> resp_cfg_ff == $past(pwdata[2*RESP_W-1:0]))
    else $error("response settings write lost");

  // Every event leaves its sticky interrupt bit set
  fault_irq_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    any_rise |=> irq_stat_ff[IRQ_FAULT])
    else $error("fault interrupt bit not set");
  handover_irq_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    handover |=> irq_stat_ff[IRQ_HANDOVER])
    else $error("handover interrupt bit not set");
  reject_irq_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (|cmd_rej) |=> irq_stat_ff[IRQ_REJECT])
    else $error("reject interrupt bit not set");
  bad_irq_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (|cmd_bad) |=> irq_stat_ff[IRQ_BADCMD])
    else $error("bad command interrupt bit not set");

endmodule : dbfsa_top

// File: shared/dbfsa_pkg.sv
// Shared constants for the dual-bus fault status arbiter
package dbfsa_pkg;

  // Number of management buses; the arbitration logic serves exactly two
  localparam int NBUS = 2;

  // Command classes delivered by each bus front end with cmd_valid
  typedef enum logic [1:0] {
    CMD_NORMAL   = 2'h0,
    CMD_BAD      = 2'h1,
    CMD_CLEAR    = 2'h2,
    CMD_TAKEOVER = 2'h3
  } dbfsa_cmd_t;

  // Fault and result inputs, one bit each, in latched status word order
  localparam int FLT_OVERVOLTAGE     = 0;
  localparam int FLT_UNDERVOLTAGE    = 1;
  localparam int FLT_OVERCURRENT     = 2;
  localparam int FLT_INPUT           = 3;
  localparam int FLT_UNKNOWN         = 4;
  localparam int FLT_INT_EXT         = 5;
  localparam int FLT_SHUTDOWN        = 6;
  localparam int FLT_OVERTEMPERATURE = 7;
  localparam int FLT_ISO_PASS        = 8;
  localparam int FLT_ISO_FAIL        = 9;
  localparam int FLT_W               = 10;

  // Status word layout: bit 1 command error, faults from bit 6 upward
  localparam int SW_W       = 16;
  localparam int SW_CML_BIT = 1;
  localparam int SW_FLT_LSB = 6;
  // Communication status byte: invalid command bit
  localparam int CML_BAD_BIT = 7;
  localparam int CML_W       = 8;

  // Transfer status nibble per bus (bus 0 low nibble, bus 1 high nibble)
  localparam int XF_CTRL  = 0;
  localparam int XF_TOOK  = 1;
  localparam int XF_EVENT = 2;
  localparam int XF_REJ   = 3;
  localparam int XF_NIB_W = 4;

  // Interrupt event bits
  localparam int IRQ_FAULT    = 0;
  localparam int IRQ_HANDOVER = 1;
  localparam int IRQ_REJECT   = 2;
  localparam int IRQ_BADCMD   = 3;
  localparam int IRQ_W        = 4;

  // APB register map (byte addresses)
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] REG_STATUS_WORD = 12'h000;
  localparam logic [11:0] REG_STATUS_CML  = 12'h004;
  localparam logic [11:0] REG_XFER_STATUS = 12'h008;
  localparam logic [11:0] REG_LIVE_STATE  = 12'h00C;
  localparam logic [11:0] REG_RESP_CFG    = 12'h010;
  localparam logic [11:0] REG_IRQ_STATUS  = 12'h014;
  localparam logic [11:0] REG_IRQ_MASK    = 12'h018;

  // Reset values
  localparam logic        CTRL_BUS_RST = 1'b0;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

endpackage : dbfsa_pkg

// File: sim/dbfsa_ctrl_model.sv
// Behavioural model of the two system controllers on the management buses
module dbfsa_ctrl_model
  import dbfsa_pkg::*;
(
  input  wire logic                        pclk,
  output logic      [dbfsa_pkg::NBUS-1:0]   cmd_valid,
  output logic      [2*dbfsa_pkg::NBUS-1:0] cmd_kind
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid = '0;
    cmd_kind  = 4'h5;
  end

  // Callers may command from the idle bus and may clear without reading status first
  task automatic send(input int b, input dbfsa_cmd_t k);
    @(posedge pclk);
    cmd_valid[b]       <= 1'b1;
    cmd_kind[2*b +: 2] <= k;
    @(posedge pclk);
    cmd_valid <= '0;
    // Idle kind lines show the inverse so a stale kind is never trusted
    cmd_kind  <= ~cmd_kind;
  endtask
endmodule // dbfsa_ctrl_model

// File: sim/dbfsa_top_test.sv
// Self-checking bench for the dual-bus fault status arbiter
module dbfsa_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dbfsa_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ctrl_bus, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  cmd_valid, alert_n, cmd_accept;
  logic [3:0]  cmd_kind;
  logic [9:0]  fault_pin;
  logic [7:0]  oc_resp, ot_resp;
  logic        err;
  int          fails, comparisons;
  logic [31:0] cfg;

  dbfsa_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .fault_pin(fault_pin),
    .alert_n(alert_n), .cmd_accept(cmd_accept), .ctrl_bus(ctrl_bus), .oc_resp(oc_resp),
    .ot_resp(ot_resp), .irq(irq));

  dbfsa_ctrl_model u_ctrl (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_line(input string what, input logic [1:0] exp, input logic [1:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Holds the request until pready is sampled high; the bench timeout bounds the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_word(what, exp, rd);
  endtask

  task automatic cmd(input int b, input dbfsa_cmd_t k, input logic [1:0] exp_alert_n);
    u_ctrl.send(b, k);
    @(negedge pclk);
    check_line("alert_n", exp_alert_n, alert_n);
  endtask

  initial begin
    #1_000_000;
    fails++;
    complete_run();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; fault_pin = 10'h000;
    void'($urandom(49942));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_line("alert_n", 2'b11, alert_n);
    rd_chk("xfer", REG_XFER_STATUS, 32'h01);
    $display("reset test done");
    cmd(1, CMD_TAKEOVER, 2'b00);
    check_line("ctrl_bus", 2'b01, {1'b0, ctrl_bus});
    rd_chk("xfer", REG_XFER_STATUS, 32'h74);
    rd_chk("status", REG_STATUS_WORD, 32'h0);
    cmd(1, CMD_CLEAR, 2'b10);
    rd_chk("xfer", REG_XFER_STATUS, 32'h14);
    cmd(0, CMD_CLEAR, 2'b11);
    rd_chk("xfer", REG_XFER_STATUS, 32'h10);
    $display("handover test done");
    cmd(0, CMD_NORMAL, 2'b10);
    check_line("accept", 2'b00, cmd_accept);
    rd_chk("xfer", REG_XFER_STATUS, 32'h1C);
    cmd(0, CMD_CLEAR, 2'b11);
    cmd(1, CMD_NORMAL, 2'b11);
    check_line("accept", 2'b10, cmd_accept);
    cmd(1, CMD_BAD, 2'b01);
    rd_chk("status", REG_STATUS_WORD, 32'h0002);
    rd_chk("cml", REG_STATUS_CML, 32'h80);
    cmd(1, CMD_CLEAR, 2'b11);
    rd_chk("cml", REG_STATUS_CML, 32'h00);
    $display("command test done");
    for (int i = 0; i < FLT_W; i++) begin
      fault_pin <= 10'h001 << i;
      repeat (6) @(posedge pclk);
      fault_pin <= 10'h000;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check_line("alert_n", 2'b00, alert_n);
      rd_chk("status", REG_STATUS_WORD, 32'h1 << (SW_FLT_LSB + i));
      rd_chk("xfer", REG_XFER_STATUS, 32'h10);
      rd_chk("live", REG_LIVE_STATE, 32'h400);
      cmd(1, CMD_CLEAR, 2'b10);
      rd_chk("status", REG_STATUS_WORD, 32'h0);
      cmd(0, CMD_CLEAR, 2'b11);
    end
    $display("fault test done");
    rd_chk("irq_status", REG_IRQ_STATUS, 32'hF);
    check_line("irq", 2'b00, {1'b0, irq});
    apb(1'b1, REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check_line("irq", 2'b01, {1'b0, irq});
    apb(1'b1, REG_IRQ_STATUS, 32'hF);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check_line("irq", 2'b00, {1'b0, irq});
    rd_chk("irq_status", REG_IRQ_STATUS, 32'h0);
    $display("interrupt test done");
    fault_pin <= 10'h004;
    repeat (8) @(posedge pclk);
    cmd(1, CMD_CLEAR, 2'b10);
    rd_chk("status", REG_STATUS_WORD, 32'h1 << (SW_FLT_LSB + 2));
    rd_chk("live", REG_LIVE_STATE, 32'h404);
    fault_pin <= 10'h000;
    repeat (4) @(posedge pclk);
    cmd(1, CMD_CLEAR, 2'b10);
    cmd(0, CMD_CLEAR, 2'b11);
    $display("relatch test done");
    cfg = $urandom & 32'hFFFF;
    apb(1'b1, REG_RESP_CFG, cfg);
    rd_chk("resp_cfg", REG_RESP_CFG, cfg);
    cmd(1, CMD_CLEAR, 2'b11);
    check_word("resp_pins", cfg, {16'h0, ot_resp, oc_resp});
    rd_chk("resp_cfg", REG_RESP_CFG, cfg);
    apb(1'b1, 12'h01C, $urandom);
    check_line("slverr", 2'b01, {1'b0, err});
    rd_chk("unmapped", 12'h01C, 32'h0);
    check_line("slverr", 2'b01, {1'b0, err});
    $display("config test done");
    // Takeover from the bus in control is ignored; a bad command from idle is rejected
    cmd(1, CMD_TAKEOVER, 2'b11);
    check_line("ctrl_bus", 2'b01, {1'b0, ctrl_bus});
    cmd(0, CMD_BAD, 2'b10);
    rd_chk("xfer", REG_XFER_STATUS, 32'h1C);
    rd_chk("status", REG_STATUS_WORD, 32'h0);
    cmd(0, CMD_CLEAR, 2'b11);
    cmd(0, CMD_TAKEOVER, 2'b00);
    check_line("ctrl_bus", 2'b00, {1'b0, ctrl_bus});
    rd_chk("xfer", REG_XFER_STATUS, 32'h47);
    cmd(0, CMD_CLEAR, 2'b01);
    rd_chk("xfer", REG_XFER_STATUS, 32'h41);
    cmd(1, CMD_CLEAR, 2'b11);
    rd_chk("xfer", REG_XFER_STATUS, 32'h01);
    $display("return test done");
    complete_run();
  end
endmodule // dbfsa_top_test
